// ---- clock_gen_pkg.sv ----
// Shared constants, types and helpers of the internal clock generator.
package clock_gen_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MULT_OFS = 8'h04;
    localparam logic [7:0] TRIM_OFS = 8'h08;
    localparam logic [7:0] DIV_OFS = 8'h0C;
    localparam logic [7:0] STAGE_OFS = 8'h10;
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_MULT = 3'h1;
    localparam logic [2:0] IDX_TRIM = 3'h2;
    localparam logic [2:0] IDX_DIV = 3'h3;
    localparam logic [2:0] IDX_STAGE = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_FAULT = 6;
    localparam int BIT_MON_EN = 5;
    localparam int BIT_SEL = 4;
    localparam int BIT_INT_EN = 3;
    localparam int BIT_INT_STABLE = 2;
    localparam int BIT_EXT_EN = 1;
    localparam int BIT_EXT_STABLE = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] MULT_RESET = 7'h15;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [3:0] DIV_RESET = 4'h4;
    localparam logic [7:0] STAGE_RESET = 8'h80;

    // ------------------------------------------------------------
    // Oscillator and loop filter
    // ------------------------------------------------------------
    localparam logic [3:0] EXP_MAX = 4'h9;
    localparam logic [11:0] COMBINED_MAX = 12'h9FF;
    localparam logic [11:0] COARSE_STEP = 12'h020;
    localparam logic [11:0] FINE_STEP = 12'h001;
    localparam logic [5:0] STAGE_BASE = 6'h11;
    localparam logic [5:0] STAGE_INC = 6'h02;
    localparam logic [5:0] STAGE_LONG_TOP = 6'h22;
    localparam logic [2:0] RING_TOP_CODE = 3'h7;
    localparam logic [1:0] CORR_BASE_LAST = 2'h3;
    localparam logic [15:0] CORR_BASE_PERIODS = 16'h0004;
    localparam logic [23:0] ERR_COARSE_PCT = 24'h00000F;
    localparam logic [23:0] ERR_STABLE_PCT = 24'h000005;
    localparam logic [23:0] PCT_FULL = 24'h000064;
    localparam int BASE_REF_FREQ_HZ = 307200;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOSS_TIME_NS = 20000;
    localparam logic [11:0] LOSS_CYCLES = 12'(LOSS_TIME_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Codes above the top one behave as the top one
    function automatic logic [3:0] eff_exp(input logic [3:0] code);
        eff_exp = (code > EXP_MAX) ? EXP_MAX : code;
    endfunction

endpackage

// ---- ring_period_gen.sv ----
// Variable-delay ring model with fine adjust over a 32-cycle pattern.
`timescale 1ns/1ns
module ring_period_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [7:0] stage_word,
    // Ring output
    output logic ring_tick
);
    import clock_gen_pkg::*;

    typedef struct packed {
        logic [5:0] delay_cnt;
        logic [4:0] cycle_idx;
        logic tick;
    } ring_state_t;

    ring_state_t s_reg, s_next;
    logic [5:0] base_len;
    logic [5:0] period;

    always_comb begin
        base_len = STAGE_BASE + STAGE_INC * {3'h0, stage_word[7:5]};
        period = base_len;
        if (s_reg.cycle_idx < stage_word[4:0]) begin
            period = (stage_word[7:5] == RING_TOP_CODE) ? STAGE_LONG_TOP : base_len + STAGE_INC;
        end
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.delay_cnt = 6'h00;
            s_next.cycle_idx = 5'h00;
        end else if (s_reg.delay_cnt >= period - 6'h01) begin
            s_next.delay_cnt = 6'h00;
            s_next.cycle_idx = s_reg.cycle_idx + 5'h01;
            s_next.tick = 1'b1;
        end else begin
            s_next.delay_cnt = s_reg.delay_cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ring_tick = s_reg.tick;
endmodule

// ---- binary_divider.sv ----
// Power-of-two divider between ring output and internal clock.
`timescale 1ns/1ns
module binary_divider (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [3:0] exponent,
    input wire logic ring_tick,
    // Divided output
    output logic out_tick
);
    import clock_gen_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t s_reg, s_next;
    logic [8:0] last;

    always_comb begin
        // divide by two to the exponent
        last = 9'((10'h001 << eff_exp(exponent)) - 10'h001);
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.cnt = 9'h000;
        end else if (ring_tick) begin
            if (s_reg.cnt >= last) begin
                s_next.cnt = 9'h000;
                s_next.tick = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign out_tick = s_reg.tick;
endmodule

// ---- internal_clock_gen.sv ----
// Internal clock generator: registers, loop filter, monitor, source switch.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// How it works
// - Reading control while fault set arms the flag clear.
// - Lost selected source is deselected; other one drives base clock.
// - Divider divides ring output by two to the exponent, up to 512.
// - Exponent codes above nine behave as nine.
// - Loop moves exponent only by carry or borrow from the stage word.
// - Upper stage bits pick 17 to 31 stage delays in steps of two.
// - Lower stage bits set long-point cycles out of every 32.
// - Top ring code forms its long point as 34 delays.
// - Above 15 percent error, corrections step the lowest ring bit.
// - The smallest correction is one stage word count.
// - Loop targets multiply factor times base reference frequency.
// - Monitor enable refused until internal clock stable again.
// - No interlock blocks multiply factor changes while running.
// - Loop restarts settling on reset, factor, trim or enable.
// - Each correction spans four base reference periods.
// - Coarse steps: eight corrections double or halve the period.
// - Source select write needs requested clock enabled and stable.
// - Monitor enable sets only with both clocks enabled and stable.
// - Internal stable set once error is within 5 percent.
// - Exponent and stage word writable only while generator is off.
// ----------------------------------------------------------------
module internal_clock_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register bus
    input wire clock_gen_pkg::apb_req_t apb_i,
    output clock_gen_pkg::apb_rsp_t apb_o,
    // Clock sources
    input wire logic base_ref_tick,
    input wire logic ext_clk_tick,
    input wire logic ext_clk_ready,
    // Clock outputs
    output logic internal_clock,
    output logic selected_base_clock,
    output logic clock_select
);
    import clock_gen_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic irq_en;
        logic fault;
        logic mon_en;
        logic sel;
        logic int_en;
        logic int_stable;
        logic ext_en;
        logic ext_stable;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic fault_armed;
        logic [6:0] mult;
        logic [7:0] trim;
        logic [11:0] combined;
        logic restart;
        logic int_en_d;
        logic [1:0] base_cnt;
        logic [15:0] win_cnt;
        logic win_open;
        logic [11:0] int_idle;
        logic [11:0] ext_idle;
        logic sel_pulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gen_state_t;

    gen_state_t s_reg, s_next;
    logic ring_tick;
    logic int_tick;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            CTRL_OFS: reg_index = IDX_CTRL;
            MULT_OFS: reg_index = IDX_MULT;
            TRIM_OFS: reg_index = IDX_TRIM;
            DIV_OFS: reg_index = IDX_DIV;
            STAGE_OFS: reg_index = IDX_STAGE;
            default: reg_index = IDX_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------
    ring_period_gen u_ring (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(s_reg.ctrl.int_en),
        .stage_word(s_reg.combined[7:0]),
        .ring_tick(ring_tick)
    );

    binary_divider u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(s_reg.ctrl.int_en),
        .exponent(s_reg.combined[11:8]),
        .ring_tick(ring_tick),
        .out_tick(int_tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic [2:0] idx;
    logic [7:0] wd;
    logic [15:0] target;
    logic [23:0] diff;
    logic [11:0] step;
    logic [12:0] sum;
    logic set_fault;
    logic int_lost;
    logic ext_lost;

    always_comb begin
        s_next = s_reg;
        setup = apb_i.psel && !apb_i.penable;
        access = apb_i.psel && apb_i.penable && s_reg.pready;
        idx = reg_index(apb_i.paddr);
        wd = apb_i.pwdata[7:0];
        target = 16'h0000;
        diff = 24'h000000;
        step = FINE_STEP;
        sum = 13'h0000;
        set_fault = 1'b0;
        int_lost = 1'b0;
        ext_lost = 1'b0;

        // No wait state; the setup cycle registers every answer so it comes from a flop
        s_next.pready = setup;
        s_next.restart = 1'b0;
        s_next.int_en_d = s_reg.ctrl.int_en;
        s_next.pslverr = setup && (idx == IDX_NONE);
        if (setup) begin
            case (idx)
                IDX_CTRL: s_next.prdata = {24'h000000, s_reg.ctrl};
                IDX_MULT: s_next.prdata = {25'h0000000, s_reg.mult};
                IDX_TRIM: s_next.prdata = {24'h000000, s_reg.trim};
                IDX_DIV: s_next.prdata = {28'h0000000, s_reg.combined[11:8]};
                IDX_STAGE: s_next.prdata = {24'h000000, s_reg.combined[7:0]};
                default: s_next.prdata = 32'h00000000;
            endcase
        end

        if (access && !apb_i.pwrite && idx == IDX_CTRL && s_reg.ctrl.fault) begin
            s_next.fault_armed = 1'b1;
        end

        if (access && apb_i.pwrite) begin
            case (idx)
                IDX_CTRL: begin
                    if (s_reg.fault_armed && !wd[BIT_FAULT]) begin
                        s_next.ctrl.fault = 1'b0;
                    end
                    s_next.fault_armed = 1'b0;
                    // Selected source cannot be switched off
                    if (wd[BIT_INT_EN] || s_reg.ctrl.sel) begin
                        s_next.ctrl.int_en = wd[BIT_INT_EN];
                    end
                    if (wd[BIT_EXT_EN] || !s_reg.ctrl.sel) begin
                        s_next.ctrl.ext_en = wd[BIT_EXT_EN];
                    end
                    // switch only to a ready clock
                    if (wd[BIT_SEL] && s_reg.ctrl.ext_en && s_reg.ctrl.ext_stable) begin
                        s_next.ctrl.sel = 1'b1;
                    end else if (!wd[BIT_SEL] && s_reg.ctrl.int_en && s_reg.ctrl.int_stable) begin
                        s_next.ctrl.sel = 1'b0;
                    end
                    s_next.ctrl.mon_en = wd[BIT_MON_EN] && s_reg.ctrl.int_en
                        && s_reg.ctrl.int_stable && s_reg.ctrl.ext_en && s_reg.ctrl.ext_stable;
                    s_next.ctrl.irq_en = wd[BIT_IRQ_EN] && s_next.ctrl.mon_en;
                end
                IDX_MULT: begin
                    s_next.mult = apb_i.pwdata[6:0];
                    s_next.restart = 1'b1;
                end
                IDX_TRIM: begin
                    s_next.trim = wd;
                    s_next.restart = 1'b1;
                end
                IDX_DIV: begin
                    if (!s_reg.ctrl.int_en) begin
                        s_next.combined[11:8] = apb_i.pwdata[3:0];
                    end
                end
                IDX_STAGE: begin
                    if (!s_reg.ctrl.int_en) begin
                        s_next.combined[7:0] = wd;
                    end
                end
                default: begin
                end
            endcase
        end

        // External side stability follows its enable and the ready input
        s_next.ctrl.ext_stable = s_reg.ctrl.ext_en && ext_clk_ready;

        // ----------------------------------------------------------
        // Loop filter
        // ----------------------------------------------------------
        // target is four times factor
        target = CORR_BASE_PERIODS * {9'h000, s_reg.mult};
        diff = (s_reg.win_cnt > target) ? {8'h00, s_reg.win_cnt - target}
            : {8'h00, target - s_reg.win_cnt};
        if (!s_reg.ctrl.int_en || s_reg.restart || (s_reg.ctrl.int_en && !s_reg.int_en_d)) begin
            s_next.base_cnt = 2'h0;
            s_next.win_cnt = 16'h0000;
            s_next.win_open = 1'b0;
            s_next.ctrl.int_stable = 1'b0;
        end else if (base_ref_tick && !s_reg.win_open) begin
            // Open on a base edge so the first window is full length
            s_next.win_open = 1'b1;
            s_next.win_cnt = {15'h0000, int_tick};
        end else if (base_ref_tick && s_reg.base_cnt == CORR_BASE_LAST) begin
            s_next.base_cnt = 2'h0;
            s_next.win_cnt = {15'h0000, int_tick};
            // coarse steps halve or double in eight
            step = (diff * PCT_FULL > {8'h00, target} * ERR_COARSE_PCT) ? COARSE_STEP : FINE_STEP;
            // one step on the joined value
            if (s_reg.win_cnt > target) begin
                sum = {1'b0, s_reg.combined} + {1'b0, step};
                s_next.combined = (sum > {1'b0, COMBINED_MAX}) ? COMBINED_MAX : sum[11:0];
            end else if (s_reg.win_cnt < target) begin
                s_next.combined = (s_reg.combined < step) ? 12'h000 : s_reg.combined - step;
            end
            if (diff * PCT_FULL <= {8'h00, target} * ERR_STABLE_PCT) begin
                s_next.ctrl.int_stable = 1'b1;
            end
        end else begin
            if (base_ref_tick) begin
                s_next.base_cnt = s_reg.base_cnt + 2'h1;
            end
            if (int_tick && s_reg.win_cnt != 16'hFFFF) begin
                s_next.win_cnt = s_reg.win_cnt + 16'h0001;
            end
        end

        // ----------------------------------------------------------
        // Clock monitor
        // ----------------------------------------------------------
        if (!s_reg.ctrl.mon_en) begin
            s_next.int_idle = 12'h000;
            s_next.ext_idle = 12'h000;
        end else begin
            s_next.int_idle = int_tick ? 12'h000
                : (s_reg.int_idle == LOSS_CYCLES ? LOSS_CYCLES : s_reg.int_idle + 12'h001);
            s_next.ext_idle = ext_clk_tick ? 12'h000
                : (s_reg.ext_idle == LOSS_CYCLES ? LOSS_CYCLES : s_reg.ext_idle + 12'h001);
            int_lost = (s_reg.int_idle == LOSS_CYCLES);
            ext_lost = (s_reg.ext_idle == LOSS_CYCLES);
            set_fault = int_lost || ext_lost;
        end
        // fail over to the live source
        if (int_lost && !s_reg.ctrl.sel) begin
            s_next.ctrl.sel = 1'b1;
        end else if (ext_lost && s_reg.ctrl.sel) begin
            s_next.ctrl.sel = 1'b0;
        end
        // New loss beats a clear in the same cycle
        if (set_fault) begin
            s_next.ctrl.fault = 1'b1;
        end

        s_next.sel_pulse = s_reg.ctrl.sel ? ext_clk_tick : int_tick;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.ctrl.int_en <= 1'b1;
            s_reg.mult <= MULT_RESET;
            s_reg.trim <= TRIM_RESET;
            s_reg.combined <= {DIV_RESET, STAGE_RESET};
            s_reg.restart <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign apb_o.pready = s_reg.pready;
    assign apb_o.pslverr = s_reg.pslverr;
    assign apb_o.prdata = s_reg.prdata;
    assign internal_clock = int_tick;
    assign selected_base_clock = s_reg.sel_pulse;
    assign clock_select = s_reg.ctrl.sel;
endmodule

// ---- ref_source_model.sv ----
// Behavioural base reference and external clock source.
`timescale 1ns/1ns
module ref_source_model #(
    parameter int BASE_PERIOD = 326,
    parameter int EXT_PERIOD = 7
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control from the bench
    input wire logic ext_run,
    // Source outputs
    output logic base_ref_tick,
    output logic ext_clk_tick,
    output logic ext_clk_ready
);
    int base_cnt;
    int ext_cnt;
    // A stopped crystal loses its ready indication too
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt <= 0;
            ext_cnt <= 0;
            base_ref_tick <= 1'b0;
            ext_clk_tick <= 1'b0;
            ext_clk_ready <= 1'b0;
        end else begin
            base_cnt <= (base_cnt == BASE_PERIOD - 1) ? 0 : base_cnt + 1;
            ext_cnt <= (ext_cnt == EXT_PERIOD - 1) ? 0 : ext_cnt + 1;
            base_ref_tick <= (base_cnt == BASE_PERIOD - 1);
            ext_clk_tick <= ext_run && (ext_cnt == EXT_PERIOD - 1);
            ext_clk_ready <= ext_run && (ext_clk_ready || ext_clk_tick);
        end
    end
endmodule

// ---- clock_gen_asserts.sv ----
// Checker of bus handshake, clock routing and the minimum oscillator period.
`timescale 1ns/1ns
module clock_gen_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register bus
    input wire clock_gen_pkg::apb_req_t apb_i,
    input wire clock_gen_pkg::apb_rsp_t apb_o,
    // Clock sources
    input wire logic base_ref_tick,
    input wire logic ext_clk_tick,
    input wire logic ext_clk_ready,
    // Clock outputs
    input wire logic internal_clock,
    input wire logic selected_base_clock,
    input wire logic clock_select
);
    import clock_gen_pkg::*;
    logic [15:0] gap_reg;
    logic [15:0] gap_next;
    logic seen_reg;
    logic mapped;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    assign mapped = apb_i.paddr inside {CTRL_OFS, MULT_OFS, TRIM_OFS, DIV_OFS, STAGE_OFS};
    // Cycles since the last internal pulse, saturating
    always_comb begin
        gap_next = (gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001;
        if (internal_clock) begin
            gap_next = 16'h0000;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 16'h0000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_reg | internal_clock;
        end
    end
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_done;
        apb_o.pready && apb_i.psel && apb_i.penable;
    endsequence
    property p_ready_after_setup;
        s_setup |=> apb_o.pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("late ready");
    property p_ready_lone;
        apb_o.pready |=> !apb_o.pready;
    endproperty
    a_ready_lone: assert property (p_ready_lone) else $error("ready held");
    property p_err_unmapped;
        s_done ##0 !mapped |-> apb_o.pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_err_data;
        apb_o.pslverr |-> apb_o.pready && apb_o.prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error response carries data");
    property p_rd_width;
        s_done ##0 !apb_i.pwrite |-> apb_o.prdata[31:8] == 24'h0;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
    property p_sel_copy;
        $past(rst_n) && $stable(clock_select) |-> selected_base_clock ==
            (clock_select ? $past(ext_clk_tick) : $past(internal_clock));
    endproperty
    a_sel_copy: assert property (p_sel_copy) else $error("wrong base source");
    property p_sel_needs_ready;
        $rose(clock_select) |-> $past(ext_clk_ready, 2);
    endproperty
    a_sel_needs_ready: assert property (p_sel_needs_ready) else $error("select early");
    property p_gap;
        internal_clock && seen_reg |-> gap_reg >= 16'h0010;
    endproperty
    a_gap: assert property (p_gap) else $error("internal period short");
endmodule

// ---- testbench.sv ----
// Self-checking bench: registers, source switching, failover and settling.
`timescale 1ns/1ns
module testbench;
    import clock_gen_pkg::*;
    typedef struct packed {
        logic err;
        logic [31:0] data;
        logic [31:0] mask;
    } note_t;
    logic core_clk, rst_n, ext_run;
    apb_req_t apb_i;
    apb_rsp_t apb_o;
    logic base_ref_tick, ext_clk_tick, ext_clk_ready;
    logic internal_clock, selected_base_clock, clock_select;
    note_t exp_q[$];
    logic [31:0] rdv;
    logic [3:0] d;
    logic [7:0] s;
    int waitn;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    internal_clock_gen DUT (.core_clk(core_clk), .rst_n(rst_n), .apb_i(apb_i), .apb_o(apb_o),
        .base_ref_tick(base_ref_tick), .ext_clk_tick(ext_clk_tick),
        .ext_clk_ready(ext_clk_ready), .internal_clock(internal_clock),
        .selected_base_clock(selected_base_clock), .clock_select(clock_select));
    // Base period kept under the loss time; the monitor watches only the internal and external ticks, not this one
    ref_source_model #(.BASE_PERIOD(1000), .EXT_PERIOD(7)) SRC (.core_clk(core_clk),
        .rst_n(rst_n), .ext_run(ext_run), .base_ref_tick(base_ref_tick),
        .ext_clk_tick(ext_clk_tick), .ext_clk_ready(ext_clk_ready));

    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic fail(input string msg);
        fail_count++;
        $display("FAIL %0t %s", $time, msg);
    endtask
    task automatic cmp_pin(input logic got, input logic want);
        n_tests++;
        if (got !== want) fail("clock select level");
    endtask
    task automatic cmp_rsp(input note_t nt);
        n_tests++;
        if (apb_o.pslverr !== nt.err || ((apb_o.prdata ^ nt.data) & nt.mask) !== 32'h0)
            fail("bus response");
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat,
            input logic [31:0] e, input logic [31:0] m);
        int n;
        n = 0;
        exp_q.push_back('{!(a inside {CTRL_OFS, MULT_OFS, TRIM_OFS, DIV_OFS, STAGE_OFS}), e, m});
        @(posedge core_clk);
        apb_i <= '{1'b1, 1'b0, w, a, dat};
        @(posedge core_clk);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_o.pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no ready");
        rdv = apb_o.prdata;
        apb_i <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        xfer(1'b1, a, dat, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0, e, m);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            rd(CTRL_OFS, 32'h0, 32'h0);
            n++;
        end while (rdv[b] !== 1'b1 && n < 5000);
        if (n >= 5000) fail("flag never set");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Response watcher and hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (rst_n === 1'b1 && apb_o.pready === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected response");
            else cmp_rsp(exp_q.pop_front());
        end
        if (cycles == 80000) begin
            fail("timeout");
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h186D));
        rst_n = 1'b0;
        ext_run = 1'b1;
        apb_i = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(CTRL_OFS, 32'h08, 32'hFFFF_FFFB);
        rd(MULT_OFS, 32'(MULT_RESET), '1);
        rd(TRIM_OFS, 32'(TRIM_RESET), '1);
        rd(DIV_OFS, 32'(DIV_RESET), '1);
        rd(STAGE_OFS, 32'(STAGE_RESET), '1);
        wr(8'h14, 32'hFF);
        rd(8'h14, 32'h0, '1);
        wr(DIV_OFS, 32'h2);
        rd(DIV_OFS, 32'(DIV_RESET), '1);
        wr(CTRL_OFS, 32'h18);
        rd(CTRL_OFS, 32'h08, 32'h1A);
        cmp_pin(clock_select, 1'b0);
        wr(CTRL_OFS, 32'h0A);
        poll(BIT_EXT_STABLE);
        wr(CTRL_OFS, 32'h1A);
        rd(CTRL_OFS, 32'h1B, 32'h1B);
        cmp_pin(clock_select, 1'b1);
        wr(CTRL_OFS, 32'h12);
        wr(CTRL_OFS, 32'h32);
        rd(CTRL_OFS, 32'h10, 32'h38);
        repeat (3) begin
            d = 4'($urandom);
            s = 8'($urandom);
            wr(DIV_OFS, 32'(d));
            wr(STAGE_OFS, 32'(s));
            rd(DIV_OFS, 32'(d), '1);
            rd(STAGE_OFS, 32'(s), '1);
        end
        // Start point near 47.6 cycles: 23.8 delays, divide by two
        wr(DIV_OFS, 32'h1);
        wr(STAGE_OFS, 32'h6D);
        wr(CTRL_OFS, 32'h1A);
        poll(BIT_INT_STABLE);
        wr(CTRL_OFS, 32'h3A);
        rd(CTRL_OFS, 32'h3F, 32'h7F);
        ext_run <= 1'b0;
        waitn = 0;
        while (clock_select !== 1'b0 && waitn < 2500) begin
            @(posedge core_clk);
            waitn++;
        end
        cmp_pin(clock_select, 1'b0);
        wr(CTRL_OFS, 32'h0A);
        rd(CTRL_OFS, 32'h40, 32'h70);
        wr(CTRL_OFS, 32'h0A);
        rd(CTRL_OFS, 32'h00, 32'h40);
        ext_run <= 1'b1;
        poll(BIT_EXT_STABLE);
        wr(MULT_OFS, 32'h16);
        rd(MULT_OFS, 32'h16, '1);
        wr(CTRL_OFS, 32'hAA);
        rd(CTRL_OFS, 32'h00, 32'hA4);
        give_verdict();
    end
endmodule

bind internal_clock_gen clock_gen_asserts chk (.core_clk(core_clk), .rst_n(rst_n),
    .apb_i(apb_i), .apb_o(apb_o), .base_ref_tick(base_ref_tick),
    .ext_clk_tick(ext_clk_tick), .ext_clk_ready(ext_clk_ready),
    .internal_clock(internal_clock), .selected_base_clock(selected_base_clock),
    .clock_select(clock_select));
